/* design/vpw_link_ctrl.sv */
// Controller that encodes and decodes pulse width frames on the transceiver pins
`timescale 1ns/1ps
`default_nettype none
module vpw_link_ctrl
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic TX_START,
   input wire logic [7:0] TX_DATA,
   input wire logic LOOPBACK_REQ,
   input wire logic RX_PIN,
   output logic TX_PIN,
   output logic TX_ENABLE,
   output logic LOOP_SELECT,
   output logic TX_BUSY,
   output logic TX_LOST,
   output logic TX_DONE,
   output logic RX_VALID,
   output logic [7:0] RX_DATA,
   output logic RX_SOF,
   output logic RX_EOD
);
   typedef enum logic [2:0] {ST_IDLE, ST_SOF, ST_BIT, ST_EOD} vpw_state_type;

   logic edge_seen;
   logic level_before;
   logic [vpw_pkg::CNT_W-1:0] width;
   logic [vpw_pkg::CNT_W-1:0] rx_cnt;

   vpw_pulse_timer u_timer
   (
      .clk(REF_CLK),
      .nrst(NRST),
      .line_in(RX_PIN),
      .edge_seen(edge_seen),
      .level_before(level_before),
      .width(width),
      .count(rx_cnt)
   );

   // Receive side
   logic in_frame_reg, in_frame_next;
   logic [7:0] sh_reg, sh_next;
   logic [2:0] nb_reg, nb_next;
   vpw_pkg::vpw_byte_type rxb_reg, rxb_next;
   vpw_pkg::vpw_event_type ev_reg, ev_next;
   logic bus_idle;

   assign bus_idle = !level_before && (rx_cnt >= vpw_pkg::CNT_W'(vpw_pkg::IDLE_CYC));

   always_comb
   begin
      in_frame_next = in_frame_reg;
      sh_next = sh_reg;
      nb_next = nb_reg;
      rxb_next = '{valid: 1'b0, data: rxb_reg.data};
      ev_next = '{sof: 1'b0, eod: 1'b0, lost: 1'b0};
      if (edge_seen)
      begin
         if (level_before && width >= vpw_pkg::CNT_W'(vpw_pkg::SOF_MIN_CYC)
             && !in_frame_reg)
         begin
            in_frame_next = 1'b1;
            nb_next = vpw_pkg::BIT_ZERO;
            sh_next = vpw_pkg::BYTE_ZERO;
            ev_next.sof = 1'b1;
         end
         else if (in_frame_reg)
         begin
            // Long low or short high is zero, else one
            sh_next = {sh_reg[6:0],
                       (width >= vpw_pkg::CNT_W'(vpw_pkg::THRESH_CYC)) ^ !level_before};
            nb_next = nb_reg + 3'h1;
            if (nb_reg == vpw_pkg::BIT_LAST)
            begin
               rxb_next = '{valid: 1'b1, data: sh_next};
            end
         end
      end
      else if (in_frame_reg && !level_before
               && rx_cnt == vpw_pkg::CNT_W'(vpw_pkg::SOF_MIN_CYC))
      begin
         in_frame_next = 1'b0;
         ev_next.eod = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         in_frame_reg <= 1'b0;
         sh_reg <= vpw_pkg::BYTE_ZERO;
         nb_reg <= vpw_pkg::BIT_ZERO;
         rxb_reg <= '0;
         ev_reg <= '0;
      end
      else
      begin
         in_frame_reg <= in_frame_next;
         sh_reg <= sh_next;
         nb_reg <= nb_next;
         rxb_reg <= rxb_next;
         ev_reg <= ev_next;
      end
   end

   // Transmit side
   vpw_state_type st_reg, st_next;
   logic [vpw_pkg::CNT_W-1:0] tc_reg, tc_next;
   logic [7:0] td_reg, td_next;
   logic [2:0] tb_reg, tb_next;
   logic txp_reg, txp_next;
   logic lost_reg, lost_next;
   logic done_reg, done_next;
   logic en_reg, en_next;
   logic loop_reg, loop_next;
   logic busy_reg, busy_next;
   logic [vpw_pkg::CNT_W-1:0] sym_len;

   // Length of the next bit: a one is long high or short low
   assign sym_len = (td_reg[6] ^ txp_reg) ? vpw_pkg::CW_LONG : vpw_pkg::CW_SHORT;

   always_comb
   begin
      st_next = st_reg;
      tc_next = tc_reg;
      td_next = td_reg;
      tb_next = tb_reg;
      txp_next = txp_reg;
      lost_next = 1'b0;
      done_next = 1'b0;
      en_next = 1'b1;
      loop_next = LOOPBACK_REQ;
      unique case (st_reg)
         ST_IDLE:
         begin
            txp_next = 1'b0;
            if (TX_START && bus_idle)
            begin
               st_next = ST_SOF;
               txp_next = 1'b1;
               tc_next = vpw_pkg::CW_SOF;
               td_next = TX_DATA;
            end
         end
         ST_SOF:
         begin
            tc_next = tc_reg - vpw_pkg::CNT_ONE;
            if (tc_reg == vpw_pkg::CNT_ONE)
            begin
               st_next = ST_BIT;
               txp_next = 1'b0;
               tb_next = vpw_pkg::BIT_ZERO;
               tc_next = (td_reg[7]) ? vpw_pkg::CW_SHORT : vpw_pkg::CW_LONG;
            end
         end
         ST_BIT:
         begin
            tc_next = tc_reg - vpw_pkg::CNT_ONE;
            // Bus still high while we drive low with CW_SHORT - CW_LAG cycles of the symbol left: another node won
            if (!txp_reg && level_before && !edge_seen && !loop_reg
                && tc_reg == vpw_pkg::CW_SHORT - vpw_pkg::CW_LAG)
            begin
               st_next = ST_IDLE;
               txp_next = 1'b0;
               lost_next = 1'b1;
            end
            else if (tc_reg == vpw_pkg::CNT_ONE)
            begin
               if (tb_reg == vpw_pkg::BIT_LAST)
               begin
                  st_next = ST_EOD;
                  txp_next = 1'b0;
                  tc_next = vpw_pkg::CW_EOD;
               end
               else
               begin
                  tb_next = tb_reg + 3'h1;
                  td_next = {td_reg[6:0], 1'b0};
                  txp_next = !txp_reg;
                  tc_next = sym_len;
               end
            end
         end
         ST_EOD:
         begin
            tc_next = tc_reg - vpw_pkg::CNT_ONE;
            if (tc_reg == vpw_pkg::CNT_ONE)
            begin
               st_next = ST_IDLE;
               done_next = 1'b1;
            end
         end
         default:
         begin
            st_next = ST_IDLE;
            txp_next = 1'b0;
         end
      endcase
      busy_next = (st_next != ST_IDLE);
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st_reg <= ST_IDLE;
         tc_reg <= vpw_pkg::CNT_ZERO;
         td_reg <= vpw_pkg::BYTE_ZERO;
         tb_reg <= vpw_pkg::BIT_ZERO;
         txp_reg <= 1'b0;
         lost_reg <= 1'b0;
         done_reg <= 1'b0;
         en_reg <= 1'b0;
         loop_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         tc_reg <= tc_next;
         td_reg <= td_next;
         tb_reg <= tb_next;
         txp_reg <= txp_next;
         lost_reg <= lost_next;
         done_reg <= done_next;
         en_reg <= en_next;
         loop_reg <= loop_next;
         busy_reg <= busy_next;
      end
   end

   assign TX_PIN = txp_reg;
   assign TX_ENABLE = en_reg;
   assign LOOP_SELECT = loop_reg;
   assign TX_BUSY = busy_reg;
   assign TX_LOST = lost_reg;
   assign TX_DONE = done_reg;
   assign RX_VALID = rxb_reg.valid;
   assign RX_DATA = rxb_reg.data;
   assign RX_SOF = ev_reg.sof;
   assign RX_EOD = ev_reg.eod;

   a_sof_length : assert property (@(posedge REF_CLK) disable iff (!NRST)
      (st_reg == ST_IDLE && st_next == ST_SOF) |=> txp_reg [*8])
      else $error("start symbol too short");
   a_eod_low : assert property (@(posedge REF_CLK) disable iff (!NRST)
      (st_reg == ST_EOD) |-> !txp_reg)
      else $error("end symbol not low");
   a_idle_gate : assert property (@(posedge REF_CLK) disable iff (!NRST)
      $rose(TX_BUSY) |-> $past(bus_idle))
      else $error("started without idle window");
   a_lost_stops : assert property (@(posedge REF_CLK) disable iff (!NRST)
      lost_reg |-> (st_reg == ST_IDLE && !txp_reg))
      else $error("kept sending after loss");
   a_idle_low : assert property (@(posedge REF_CLK) disable iff (!NRST)
      $fell(TX_BUSY) |-> !TX_PIN)
      else $error("transmit left high");
   a_enable_held : assert property (@(posedge REF_CLK) disable iff (!NRST)
      $past(NRST) |=> TX_ENABLE)
      else $error("transmitter enable dropped");
   a_loop_follow : assert property (@(posedge REF_CLK) disable iff (!NRST)
      $changed(LOOPBACK_REQ) |=> (LOOP_SELECT == $past(LOOPBACK_REQ)))
      else $error("loopback select not following");
   a_byte_count : assert property (@(posedge REF_CLK) disable iff (!NRST)
      RX_VALID |-> in_frame_reg && nb_reg == vpw_pkg::BIT_ZERO)
      else $error("byte out of step");
   a_timer_restart : assert property (@(posedge REF_CLK) disable iff (!NRST)
      edge_seen |=> rx_cnt == vpw_pkg::CNT_ONE)
      else $error("width counter not restarted");
endmodule // vpw_link_ctrl
`default_nettype wire

/* design/vpw_pkg.sv */
// Package of constants and types for the pulse width link controller
package vpw_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int SOF_US = 200;
   localparam int EOD_US = 200;
   localparam int THRESH_US = 96;
   localparam int IDLE_MIN_US = 280;
   localparam int SHORT_US = 64;
   localparam int LONG_US = 128;
   localparam int SOF_CYC = SOF_US * (CLK_HZ / 1000000);
   localparam int EOD_CYC = EOD_US * (CLK_HZ / 1000000);
   localparam int THRESH_CYC = THRESH_US * (CLK_HZ / 1000000);
   localparam int IDLE_CYC = IDLE_MIN_US * (CLK_HZ / 1000000);
   localparam int SHORT_CYC = SHORT_US * (CLK_HZ / 1000000);
   localparam int LONG_CYC = LONG_US * (CLK_HZ / 1000000);
   localparam int SOF_MIN_CYC = (SOF_CYC * 3) / 4;
   localparam int CNT_W = 14;
   localparam logic [CNT_W-1:0] CNT_MAX = 14'h3fff;
   localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   // Margin for the receive synchroniser before a lost arbitration is judged
   localparam int LAG_CYC = 8;
   localparam logic [CNT_W-1:0] CW_SOF = CNT_W'(SOF_CYC);
   localparam logic [CNT_W-1:0] CW_EOD = CNT_W'(EOD_CYC);
   localparam logic [CNT_W-1:0] CW_SHORT = CNT_W'(SHORT_CYC);
   localparam logic [CNT_W-1:0] CW_LONG = CNT_W'(LONG_CYC);
   localparam logic [CNT_W-1:0] CW_LAG = CNT_W'(LAG_CYC);

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } vpw_byte_type;

   typedef struct packed {
      logic sof;
      logic eod;
      logic lost;
   } vpw_event_type;
endpackage : vpw_pkg

/* design/vpw_pulse_timer.sv */
// Pulse width timer restarted on every edge of a synchronised line
`timescale 1ns/1ps
`default_nettype none
module vpw_pulse_timer
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic line_in,
   output logic edge_seen,
   output logic level_before,
   output logic [vpw_pkg::CNT_W-1:0] width,
   output logic [vpw_pkg::CNT_W-1:0] count
);
   logic s1_reg;
   logic s1_next;
   logic s2_reg;
   logic s2_next;
   logic prev_reg;
   logic prev_next;
   logic [vpw_pkg::CNT_W-1:0] cnt_reg;
   logic [vpw_pkg::CNT_W-1:0] cnt_next;

   always_comb
   begin
      s1_next = line_in;
      s2_next = s1_reg;
      prev_next = s2_reg;
      if (s2_reg != prev_reg)
      begin
         cnt_next = vpw_pkg::CNT_ONE;
      end
      else if (cnt_reg != vpw_pkg::CNT_MAX)
      begin
         cnt_next = cnt_reg + vpw_pkg::CNT_ONE;
      end
      else
      begin
         cnt_next = cnt_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         prev_reg <= 1'b0;
         cnt_reg <= vpw_pkg::CNT_ZERO;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         prev_reg <= prev_next;
         cnt_reg <= cnt_next;
      end
   end

   assign edge_seen = (s2_reg != prev_reg);
   assign level_before = prev_reg;
   assign width = cnt_reg;
   assign count = cnt_reg;
endmodule // vpw_pulse_timer
`default_nettype wire

/* sim/vpw_dev_model.sv */
// Behavioural transceiver: thermal latch, loopback, transmitter enable
`timescale 1ns/1ps
`default_nettype none
module vpw_dev_model
(
   input wire logic tx_pin,
   input wire logic tx_enable,
   input wire logic loop_select,
   input wire logic other_high,
   input wire logic [7:0] temp_c,
   output logic bus,
   output logic rx_pin
);
   localparam int TRIP_C = 150;
   localparam int HYST_C = 10;
   logic latched = 1'b0;
   logic tx_prev = 1'b0;
   // One process owns the latch: heat sets it, a cool rising edge clears it
   always @(temp_c or tx_pin)
   begin
      if (temp_c > TRIP_C)
         latched = 1'b1;
      else if (tx_pin && !tx_prev && temp_c <= TRIP_C - HYST_C)
         latched = 1'b0;
      tx_prev = tx_pin;
   end
   // Pull-down holds the bus low unless someone sources it
   assign bus = (tx_pin & tx_enable & !loop_select & !latched) | other_high;
   assign rx_pin = loop_select ? tx_pin : bus;
endmodule // vpw_dev_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the pulse width link controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, nrst, tx_start, loopback_req, other_high, prev_pin, mon_on;
   logic [7:0] tx_data, temp_c, rx_last, exp_byte, rx_data;
   logic tx_pin, tx_enable, loop_select, tx_busy, tx_lost, tx_done;
   logic rx_valid, rx_sof, rx_eod, bus, rx_pin;
   logic [31:0] seed;
   int n_mismatch, num_checks, bus_hi, n_sof, n_eod, n_lost, run, pulse;
   vpw_link_ctrl vpw_link_ctrl_inst (.REF_CLK(ref_clk), .NRST(nrst), .TX_START(tx_start),
      .TX_DATA(tx_data), .LOOPBACK_REQ(loopback_req), .RX_PIN(rx_pin), .TX_PIN(tx_pin),
      .TX_ENABLE(tx_enable), .LOOP_SELECT(loop_select), .TX_BUSY(tx_busy),
      .TX_LOST(tx_lost), .TX_DONE(tx_done), .RX_VALID(rx_valid), .RX_DATA(rx_data),
      .RX_SOF(rx_sof), .RX_EOD(rx_eod));
   vpw_dev_model vpw_dev_model_inst (.tx_pin(tx_pin), .tx_enable(tx_enable),
      .loop_select(loop_select), .other_high(other_high), .temp_c(temp_c), .bus(bus),
      .rx_pin(rx_pin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Pulse k of a frame: 0 is the start symbol, bits MSB first from a low level
   function automatic int exp_width(input logic [7:0] b, input int k);
      if (k == 0)
         return vpw_pkg::SOF_CYC;
      return (b[8-k] == k[0] ^ 1'b1) ? vpw_pkg::LONG_CYC : vpw_pkg::SHORT_CYC;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic send(input logic [7:0] b, input logic mon);
      int i;
      exp_byte = b;
      pulse = -1;
      mon_on = mon;
      tx_data = b;
      tx_start = 1'b1;
      for (i = 0; i < 8000 && tx_busy !== 1'b1; i++)
         tick();
      tx_start = 1'b0;
      check(tx_busy, 1'b1);
   endtask
   task automatic wait_end();
      int i;
      for (i = 0; i < 30000 && tx_done !== 1'b1 && tx_lost !== 1'b1; i++)
         tick();
      check(i < 30000, 1'b1);
   endtask
   task automatic wait_low();
      int i;
      for (i = 0; i < 5000 && tx_pin !== 1'b0; i++)
         tick();
   endtask
   always @(posedge ref_clk)
   begin
      if (bus) bus_hi++;
      if (rx_sof) n_sof++;
      if (rx_eod) n_eod++;
      if (tx_lost) n_lost++;
      if (rx_valid) rx_last = rx_data;
      if (mon_on && tx_busy && tx_pin !== prev_pin && pulse < 9)
      begin
         if (pulse >= 0) check(run, exp_width(exp_byte, pulse));
         pulse++;
      end
      if (mon_on && tx_done) check(run, vpw_pkg::EOD_CYC);
      run = (tx_pin === prev_pin) ? run + 1 : 1;
      prev_pin = tx_pin;
   end
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      #(50 * 98000);
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      nrst = 1'b0;
      {tx_start, loopback_req, other_high, prev_pin, mon_on} = 5'h00;
      tx_data = 8'h00;
      temp_c = 8'h19;
      {n_mismatch, num_checks, bus_hi, n_sof, n_eod, n_lost, run, pulse} = '0;
      seed = 32'hbf11;
      repeat (4) tick();
      check({tx_enable, tx_busy, tx_pin}, 3'h0);
      nrst = 1'b1;
      tick();
      check(tx_enable, 1'b1);
      seed = lfsr(seed);
      send(seed[7:0], 1'b1);
      wait_end();
      check(rx_last, seed[7:0]);
      check({n_sof[1:0], n_eod[1:0]}, 4'h5);
      tx_start = 1'b1;
      repeat (200) tick();
      check(tx_busy, 1'b0);
      tx_start = 1'b0;
      loopback_req = 1'b1;
      temp_c = 8'ha0;
      tick();
      tick();
      check(loop_select, 1'b1);
      bus_hi = 0;
      send(8'hff, 1'b1);
      wait_end();
      check(rx_last, 8'hff);
      check(bus_hi, 0);
      loopback_req = 1'b0;
      temp_c = 8'h91;
      bus_hi = 0;
      seed = lfsr(seed);
      send(seed[7:0], 1'b0);
      wait_low();
      check(bus_hi, 0);
      temp_c = 8'h82;
      wait_end();
      check(bus_hi > 0, 1'b1);
      send(8'h00, 1'b0);
      wait_low();
      other_high = 1'b1;
      wait_end();
      tick();
      other_high = 1'b0;
      check(n_lost, 1);
      check(tx_busy, 1'b0);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
